/* File: dpc_debug_port_ctrl.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - compare match sets sticky compare flag
// - mode: normal, verify, compare, reserved
// - enabled overrun sets sticky overrun flag
// - overrun detect enable written, resets zero
// - lane mask used only in pushed modes
// - each mask bit includes one byte lane
// - mask none or all compares whole word
// - normal mode forwards access unchanged
// - pushed write becomes read then compare
// - writing zero never clears set flag
// - scan chain: write one clears flag
// - serial wire: abort fields clear flags
// - serial wire: flags read only here
// - scan chain: select readable and writable
// - serial wire: select write only
// - select picks port and register bank
// - serial wire: select bit0 is bank
// - missing port: reads zero, writes dropped
// - bank bit maps ctrl or wire control
// - access-port error sets sticky error
module dpc_debug_port_ctrl #(
    parameter bit SERIAL_WIRE = 1'b0,
    parameter int unsigned NUM_AP = 1
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic clk_link,
    input wire logic link_req,
    input wire dpc_pkg::dpc_link_req_s link_cmd,
    output logic link_done,
    output logic [31:0] link_rdata,
    output logic ap_valid,
    output dpc_pkg::dpc_ap_req_s ap_cmd,
    input wire logic ap_ack,
    input wire logic [31:0] ap_rdata,
    input wire logic ap_err
);
    import dpc_pkg::*;

    localparam logic [8:0] NUM_AP_W = 9'(NUM_AP);

    // port numbers are eight bits wide, and at least one port must exist
    if (NUM_AP < 1 || NUM_AP > 256) begin : g_bad_num_ap
        $error("NUM_AP must lie between 1 and 256");
    end

    typedef struct packed {
        logic busy;
        logic req_tgl;
        logic orun_tgl;
        dpc_link_req_s held;
        logic ack_s1;
        logic ack_s2;
        logic ack_s3;
        logic done;
        logic [31:0] rdata;
    } dpc_link_s;

    typedef struct packed {
        logic req_s1;
        logic req_s2;
        logic req_s3;
        logic orun_s1;
        logic orun_s2;
        logic orun_s3;
        logic ack_tgl;
        logic [31:0] rdata;
        dpc_state_e st;
        logic orun_en;
        logic [1:0] mode;
        logic [3:0] mask;
        logic err;
        logic cmp;
        logic orun;
        logic [7:0] port;
        logic [3:0] pbank;
        logic bank_sel;
        logic ap_valid;
        dpc_ap_req_s ap;
        logic pushed;
    } dpc_sys_s;

    dpc_link_s lk;
    dpc_link_s next_lk;
    dpc_sys_s sy;
    dpc_sys_s next_sy;

    logic ack_edge;
    logic req_new;
    logic orun_evt;
    logic is_pushed;
    logic set_err;
    logic set_cmp;
    logic set_orun;
    logic clr_err;
    logic clr_cmp;
    logic clr_orun;
    logic cmp_hit;
    logic [31:0] lane_word;
    logic [31:0] cmp_mask;
    logic [31:0] ctrl_word;
    logic [31:0] sel_word;

    // ---------------- link domain ----------------
    // held request stays frozen while busy, so the system side may read it
    // once the toggle has passed its two flops
    always_comb begin
        next_lk = lk;
        next_lk.ack_s1 = sy.ack_tgl;
        next_lk.ack_s2 = lk.ack_s1;
        next_lk.ack_s3 = lk.ack_s2;
        next_lk.done = 1'h0;
        ack_edge = lk.ack_s2 ^ lk.ack_s3;
        if (ack_edge) begin
            next_lk.busy = 1'h0;
            next_lk.done = 1'h1;
            next_lk.rdata = sy.rdata;
        end
        if (link_req) begin
            if (lk.busy && !ack_edge) begin
                next_lk.orun_tgl = ~lk.orun_tgl; // dropped, reported as overrun
            end else begin
                next_lk.held = link_cmd;
                next_lk.req_tgl = ~lk.req_tgl;
                next_lk.busy = 1'h1;
            end
        end
    end

    always_ff @(posedge clk_link or negedge rstn) begin
        if (!rstn) begin
            lk <= '0;
        end else begin
            lk <= next_lk;
        end
    end

    assign link_done = lk.done;
    assign link_rdata = lk.rdata;

    // ---------------- system domain ----------------
    // per-lane byte mask built from the lane field
    for (genvar i = 0; i < 4; i++) begin : g_lane
        assign lane_word[8*i+:8] = sy.mask[i] ? DPC_LANE_ONES : '0;
    end

    // none or all lanes means the full word
    assign cmp_mask = (sy.mask == DPC_LANES_NONE || sy.mask == DPC_LANES_ALL) ?
        DPC_WORD_ONES : lane_word;

    // reserved mode code behaves as normal forwarding
    assign is_pushed = (sy.mode == DPC_MODE_VERIFY) || (sy.mode == DPC_MODE_COMPARE);

    // readback words
    always_comb begin
        ctrl_word = '0;
        ctrl_word[DPC_CS_ORUN_EN] = sy.orun_en;
        ctrl_word[DPC_CS_ORUN] = sy.orun;
        ctrl_word[DPC_CS_MODE_LO+:2] = sy.mode;
        ctrl_word[DPC_CS_CMP] = sy.cmp;
        ctrl_word[DPC_CS_ERR] = sy.err;
        ctrl_word[DPC_CS_MASK_LO+:4] = sy.mask;
        sel_word = '0;
        sel_word[DPC_SEL_PBANK_LO+:4] = sy.pbank;
        sel_word[DPC_SEL_PORT_LO+:8] = sy.port;
    end

    // request decode, access-port sequencing and sticky flags
    always_comb begin
        next_sy = sy;
        next_sy.req_s1 = lk.req_tgl;
        next_sy.req_s2 = sy.req_s1;
        next_sy.req_s3 = sy.req_s2;
        next_sy.orun_s1 = lk.orun_tgl;
        next_sy.orun_s2 = sy.orun_s1;
        next_sy.orun_s3 = sy.orun_s2;
        req_new = sy.req_s2 ^ sy.req_s3;
        orun_evt = sy.orun_s2 ^ sy.orun_s3;
        set_err = 1'h0;
        clr_err = 1'h0;
        clr_cmp = 1'h0;
        clr_orun = 1'h0;
        cmp_hit = 1'h0;
        unique case (sy.st)
            DPC_ST_IDLE: begin
                if (req_new && lk.held.port_or_debug_select_bit) begin
                    if ({1'h0, sy.port} >= NUM_AP_W) begin
                        next_sy.rdata = '0; // absent port: no access issued
                        next_sy.ack_tgl = ~sy.ack_tgl;
                    end else begin
                        next_sy.ap_valid = 1'h1;
                        next_sy.ap.port = sy.port;
                        next_sy.ap.bank = sy.pbank;
                        next_sy.ap.addr = lk.held.addr[3:2];
                        next_sy.ap.wdata = lk.held.wdata;
                        next_sy.ap.rnw = lk.held.rnw | is_pushed;
                        next_sy.pushed = is_pushed & ~lk.held.rnw;
                        next_sy.st = DPC_ST_AP_WAIT;
                    end
                end else if (req_new) begin
                    next_sy.rdata = '0;
                    next_sy.ack_tgl = ~sy.ack_tgl;
                    if (lk.held.addr == DPC_ADDR_CTRL && !(SERIAL_WIRE && sy.bank_sel)) begin
                        // bank bit set maps the wire control word, not held here
                        if (lk.held.rnw) begin
                            next_sy.rdata = ctrl_word;
                        end else begin
                            next_sy.orun_en = lk.held.wdata[DPC_CS_ORUN_EN];
                            next_sy.mode = lk.held.wdata[DPC_CS_MODE_LO+:2];
                            next_sy.mask = lk.held.wdata[DPC_CS_MASK_LO+:4];
                            if (!SERIAL_WIRE) begin
                                clr_err = lk.held.wdata[DPC_CS_ERR];
                                clr_cmp = lk.held.wdata[DPC_CS_CMP];
                                clr_orun = lk.held.wdata[DPC_CS_ORUN];
                            end
                        end
                    end else if (lk.held.addr == DPC_ADDR_SELECT) begin
                        if (lk.held.rnw) begin
                            if (!SERIAL_WIRE) begin
                                next_sy.rdata = sel_word;
                            end
                        end else begin
                            next_sy.port = lk.held.wdata[DPC_SEL_PORT_LO+:8];
                            next_sy.pbank = lk.held.wdata[DPC_SEL_PBANK_LO+:4];
                            if (SERIAL_WIRE) begin
                                next_sy.bank_sel = lk.held.wdata[DPC_SEL_BANK_SEL];
                            end
                        end
                    end else if (lk.held.addr == DPC_ADDR_ABORT && !lk.held.rnw &&
                                 SERIAL_WIRE) begin
                        clr_err = lk.held.wdata[DPC_AB_ERR_CLR];
                        clr_cmp = lk.held.wdata[DPC_AB_CMP_CLR];
                        clr_orun = lk.held.wdata[DPC_AB_ORUN_CLR];
                    end
                end
            end
            DPC_ST_AP_WAIT: begin
                if (ap_ack) begin
                    next_sy.ap_valid = 1'h0;
                    set_err = ap_err;
                    // masked words equal counts as a match
                    cmp_hit = sy.pushed && !ap_err &&
                        ((ap_rdata & cmp_mask) == (sy.ap.wdata & cmp_mask));
                    next_sy.rdata = sy.pushed ? '0 : ap_rdata;
                    next_sy.ack_tgl = ~sy.ack_tgl;
                    next_sy.st = DPC_ST_IDLE;
                end
            end
        endcase
        set_cmp = cmp_hit;
        set_orun = orun_evt & sy.orun_en;
        // set beats clear; a zero write leaves a set flag alone
        next_sy.err = set_err | (sy.err & ~clr_err);
        next_sy.cmp = set_cmp | (sy.cmp & ~clr_cmp);
        next_sy.orun = set_orun | (sy.orun & ~clr_orun);
    end

    // all control state, flags included, clears to zero
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            sy <= '0;
        end else begin
            sy <= next_sy;
        end
    end

    assign ap_valid = sy.ap_valid;
    assign ap_cmd = sy.ap;

    // ---------------- checks ----------------
    a_cmp_set: assert property (@(posedge clk_sys) disable iff (!rstn)
        cmp_hit |=> sy.cmp)
        else $error("compare match did not set flag");

    a_cmp_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
        sy.cmp && !clr_cmp |=> sy.cmp)
        else $error("compare flag lost without clear");

    a_orun_set: assert property (@(posedge clk_sys) disable iff (!rstn)
        orun_evt && sy.orun_en |=> sy.orun)
        else $error("overrun not flagged");

    a_orun_gated: assert property (@(posedge clk_sys) disable iff (!rstn)
        !sy.orun_en && !sy.orun |=> !sy.orun)
        else $error("overrun flagged while detection off");

    a_err_set: assert property (@(posedge clk_sys) disable iff (!rstn)
        sy.st == DPC_ST_AP_WAIT && ap_ack && ap_err |=> sy.err)
        else $error("access error not flagged");

    a_pushed_read: assert property (@(posedge clk_sys) disable iff (!rstn)
        $rose(sy.ap_valid) && sy.pushed |-> sy.ap.rnw && $past(is_pushed))
        else $error("pushed write not turned into read");

    a_port_exists: assert property (@(posedge clk_sys) disable iff (!rstn)
        sy.ap_valid |-> {1'h0, sy.ap.port} < NUM_AP_W)
        else $error("access issued to absent port");

    a_full_mask: assert property (@(posedge clk_sys) disable iff (!rstn)
        sy.mask == DPC_LANES_NONE || sy.mask == DPC_LANES_ALL |-> cmp_mask == DPC_WORD_ONES)
        else $error("whole-word mask not used");

    a_ap_stable: assert property (@(posedge clk_sys) disable iff (!rstn)
        sy.ap_valid && !ap_ack |=> sy.ap_valid && $stable(sy.ap))
        else $error("access request changed while pending");

    // done is one cycle wide; the next one needs a whole new round trip
    a_done_pulse: assert property (@(posedge clk_link) disable iff (!rstn)
        link_done |=> (!link_done) [*2])
        else $error("done not a single pulse");

    // a request may follow done at once, so idle is only kept without one
    a_done_idle: assert property (@(posedge clk_link) disable iff (!rstn)
        link_done && !lk.busy && !link_req |=> !lk.busy)
        else $error("link busy without a request");

    // error and overrun flags hold just like the compare flag
    a_err_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
        sy.err && !clr_err |=> sy.err)
        else $error("error flag lost without clear");

    a_orun_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
        sy.orun && !clr_orun |=> sy.orun)
        else $error("overrun flag lost without clear");

    // normal forwarding keeps direction and data of the debugger request
    a_fwd_normal: assert property (@(posedge clk_sys) disable iff (!rstn)
        $rose(sy.ap_valid) && !sy.pushed |->
        sy.ap.rnw == lk.held.rnw && sy.ap.wdata == lk.held.wdata)
        else $error("access not forwarded unchanged");

    // select cannot change while an access is pending, the link is busy
    a_sel_route: assert property (@(posedge clk_sys) disable iff (!rstn)
        sy.ap_valid |-> sy.ap.port == sy.port && sy.ap.bank == sy.pbank)
        else $error("access not routed to selected port");

    // no compare flag can appear outside the pushed modes
    a_cmp_gated: assert property (@(posedge clk_sys) disable iff (!rstn)
        !is_pushed && !sy.cmp |=> !sy.cmp)
        else $error("compare flag set in normal mode");

    // reserved and normal codes never start a pushed operation
    a_mode_rsvd: assert property (@(posedge clk_sys) disable iff (!rstn)
        sy.mode == DPC_MODE_RSVD || sy.mode == DPC_MODE_NORMAL |-> !is_pushed)
        else $error("pushed operation in wrong mode");

    // a partial lane mask opens exactly the chosen bytes
    a_lane_mask: assert property (@(posedge clk_sys) disable iff (!rstn)
        sy.mask != DPC_LANES_NONE && sy.mask != DPC_LANES_ALL |->
        cmp_mask == {{8{sy.mask[3]}}, {8{sy.mask[2]}}, {8{sy.mask[1]}}, {8{sy.mask[0]}}})
        else $error("lane mask not applied per byte");

    // an absent port answers zero at once and sees no access
    a_absent_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
        sy.st == DPC_ST_IDLE && req_new && lk.held.port_or_debug_select_bit &&
        {1'h0, sy.port} >= NUM_AP_W |=>
        sy.rdata == '0 && !sy.ap_valid)
        else $error("absent port not answered with zero");

    // pushed writes hand no read data back
    a_pushed_rdata: assert property (@(posedge clk_sys) disable iff (!rstn)
        sy.st == DPC_ST_AP_WAIT && ap_ack && sy.pushed |=> sy.rdata == '0)
        else $error("pushed write returned read data");

    // main scenarios: compare hit, overrun, access error, done, pushed issue
    c_cmp_hit: cover property (@(posedge clk_sys) disable iff (!rstn) cmp_hit);
    c_orun: cover property (@(posedge clk_sys) disable iff (!rstn) orun_evt && sy.orun_en);
    c_ap_err: cover property (@(posedge clk_sys) disable iff (!rstn)
        sy.st == DPC_ST_AP_WAIT && ap_ack && ap_err);
    c_link_done: cover property (@(posedge clk_link) disable iff (!rstn) link_done);
    c_pushed_issue: cover property (@(posedge clk_sys) disable iff (!rstn)
        $rose(sy.ap_valid) && sy.pushed);

endmodule

/* File: dpc_pkg.sv */
package dpc_pkg;

    // debug-port register byte addresses (all four address bits compared)
    localparam logic [3:0] DPC_ADDR_ABORT = 4'h0;
    localparam logic [3:0] DPC_ADDR_CTRL = 4'h4;
    localparam logic [3:0] DPC_ADDR_SELECT = 4'h8;

    // control/status field positions
    localparam int unsigned DPC_CS_ORUN_EN = 0;
    localparam int unsigned DPC_CS_ORUN = 1;
    localparam int unsigned DPC_CS_MODE_LO = 2;
    localparam int unsigned DPC_CS_CMP = 4;
    localparam int unsigned DPC_CS_ERR = 5;
    localparam int unsigned DPC_CS_MASK_LO = 8;

    // abort register clear fields, serial-wire variant
    localparam int unsigned DPC_AB_CMP_CLR = 1;
    localparam int unsigned DPC_AB_ERR_CLR = 2;
    localparam int unsigned DPC_AB_ORUN_CLR = 4;

    // select register field positions
    localparam int unsigned DPC_SEL_BANK_SEL = 0;
    localparam int unsigned DPC_SEL_PBANK_LO = 4;
    localparam int unsigned DPC_SEL_PORT_LO = 24;

    // transfer modes
    localparam logic [1:0] DPC_MODE_NORMAL = 2'h0;
    localparam logic [1:0] DPC_MODE_VERIFY = 2'h1;
    localparam logic [1:0] DPC_MODE_COMPARE = 2'h2;
    localparam logic [1:0] DPC_MODE_RSVD = 2'h3;

    // compare masks
    localparam logic [3:0] DPC_LANES_NONE = 4'h0;
    localparam logic [3:0] DPC_LANES_ALL = 4'hF;
    localparam logic [7:0] DPC_LANE_ONES = 8'hFF;
    localparam logic [31:0] DPC_WORD_ONES = 32'hFFFFFFFF;

    // one debugger request as it arrives from the link shifter
    typedef struct packed {
        logic port_or_debug_select_bit;
        logic rnw;
        logic [3:0] addr;
        logic [31:0] wdata;
    } dpc_link_req_s;

    // one request towards the access ports
    typedef struct packed {
        logic [7:0] port;
        logic [3:0] bank;
        logic [1:0] addr;
        logic rnw;
        logic [31:0] wdata;
    } dpc_ap_req_s;

    typedef enum logic {DPC_ST_IDLE, DPC_ST_AP_WAIT} dpc_state_e;

endpackage

/* File: dpc_ap_model.sv */
`timescale 1ns/1ps
// access port stand-in: one stored word per address for each value of port bit 0, answers quickly or slowly
module dpc_ap_model (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic ap_valid,
    input wire dpc_pkg::dpc_ap_req_s ap_cmd,
    input wire logic slow,
    input wire logic err_req,
    output logic ap_ack,
    output logic [31:0] ap_rdata,
    output logic ap_err,
    output dpc_pkg::dpc_ap_req_s last_cmd,
    output logic [31:0] n_acc
);
    import dpc_pkg::*;
    logic [31:0] mem [0:7];
    int wait_cnt;

    // read data toggles when not acked, so stale data never looks valid
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < 8; i++) mem[i] <= 32'h11111111 * i;
            {ap_ack, ap_err, wait_cnt, n_acc, last_cmd} <= '0;
            ap_rdata <= 32'h5A5A5A5A;
        end else if (ap_valid && !ap_ack) begin
            if (wait_cnt < (slow ? 4 : 0)) begin
                wait_cnt <= wait_cnt + 1;
                ap_rdata <= ~ap_rdata;
            end else begin
                wait_cnt <= 0;
                ap_ack <= 1'b1;
                ap_err <= err_req;
                n_acc <= n_acc + 1;
                last_cmd <= ap_cmd;
                ap_rdata <= ap_cmd.rnw ? mem[{ap_cmd.port[0], ap_cmd.addr}] : ~ap_rdata;
                if (!ap_cmd.rnw && !err_req) mem[{ap_cmd.port[0], ap_cmd.addr}] <= ap_cmd.wdata;
            end
        end else begin
            {ap_ack, ap_err} <= 2'h0;
            ap_rdata <= ~ap_rdata;
        end
    end
endmodule

/* File: tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    import dpc_pkg::*;
    logic clk_sys = 0, clk_link = 0, rstn = 0, link_req = 0, slow = 0, err_req = 0;
    dpc_link_req_s link_cmd = '0;
    dpc_ap_req_s ap_cmd, last_cmd;
    logic link_done, ap_valid, ap_ack, ap_err;
    logic [31:0] link_rdata, ap_rdata, rd, v, n_acc, n0;
    int failures = 0, cmp_count = 0;
    // reference model of the register state and the port memories
    logic orun_en, orun, cmp, err;
    logic [1:0] mode;
    logic [3:0] mask, bank;
    logic [7:0] port;
    logic [31:0] emem [0:7];
    logic [3:0] lanes [7] = '{4'h0, 4'hF, 4'h1, 4'h2, 4'h4, 4'h8, 4'h6};

    // two unrelated clocks
    always #12.5 clk_sys = ~clk_sys;
    always #7.5 clk_link = ~clk_link;

    dpc_debug_port_ctrl #(.SERIAL_WIRE(1'b0), .NUM_AP(2)) i_dpc_debug_port_ctrl (
        .clk_sys(clk_sys), .rstn(rstn), .clk_link(clk_link), .link_req(link_req),
        .link_cmd(link_cmd), .link_done(link_done), .link_rdata(link_rdata),
        .ap_valid(ap_valid), .ap_cmd(ap_cmd), .ap_ack(ap_ack), .ap_rdata(ap_rdata),
        .ap_err(ap_err));
    dpc_ap_model i_dpc_ap_model (
        .clk_sys(clk_sys), .rstn(rstn), .ap_valid(ap_valid), .ap_cmd(ap_cmd),
        .slow(slow), .err_req(err_req), .ap_ack(ap_ack), .ap_rdata(ap_rdata),
        .ap_err(ap_err), .last_cmd(last_cmd), .n_acc(n_acc));

    task automatic end_of_test;
        if (failures == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    // one link request; hold above 1 repeats it while busy, which is an overrun
    task automatic xfer(input logic port_or_debug_select_bit, input logic rnw, input logic [3:0] a,
                        input logic [31:0] wd, input int hold);
        int n;
        @(posedge clk_link);
        link_req <= 1'b1;
        link_cmd <= '{port_or_debug_select_bit, rnw, a, wd};
        repeat (hold) @(posedge clk_link);
        link_req <= 1'b0;
        n = 0;
        do begin
            @(posedge clk_link);
            #1;
            n++;
        end while (link_done !== 1'b1 && n < 200);
        check({31'h0, link_done}, 32'h1);
        rd = link_rdata;
    endtask

    task automatic rd_ctrl;
        xfer(1'b0, 1'b1, DPC_ADDR_CTRL, 32'h0, 1);
        check(rd, {20'h0, mask, 2'h0, err, cmp, mode, orun, orun_en});
    endtask

    // scan chain: ones in the flag bits clear, zeros leave a set flag alone
    task automatic wr_ctrl(input logic [31:0] w);
        xfer(1'b0, 1'b0, DPC_ADDR_CTRL, w, 1);
        {mask, mode, orun_en} = {w[11:8], w[3:2], w[0]};
        err = err & !w[5];
        cmp = cmp & !w[4];
        orun = orun & !w[1];
        rd_ctrl();
    endtask

    task automatic sel(input logic [7:0] p, input logic [3:0] b);
        xfer(1'b0, 1'b0, DPC_ADDR_SELECT, {p, 16'h0, b, 4'h0}, 1);
        {port, bank} = {p, b};
        xfer(1'b0, 1'b1, DPC_ADDR_SELECT, 32'h0, 1);
        check(rd, {p, 16'h0, b, 4'h0});
    endtask

    // access port transfer with the expected outcome worked out alongside
    task automatic ap(input logic rnw, input logic [1:0] a, input logic [31:0] w);
        logic [2:0] idx;
        logic [31:0] m;
        logic push;
        idx = {port[0], a};
        m = (mask == 4'h0 || mask == 4'hF) ? 32'hFFFFFFFF :
            {{8{mask[3]}}, {8{mask[2]}}, {8{mask[1]}}, {8{mask[0]}}};
        push = !rnw && (mode == 2'h1 || mode == 2'h2);
        xfer(1'b1, rnw, {a, 2'h0}, w, 1);
        if (port < 8'h02) begin
            check({17'h0, last_cmd.port, last_cmd.bank, last_cmd.addr, last_cmd.rnw},
                  {17'h0, port, bank, a, rnw | push});
            check(last_cmd.wdata, w);
            if (err_req) err = 1'b1;
            else if (push) cmp = cmp | ((emem[idx] & m) == (w & m));
            else if (rnw) check(rd, emem[idx]);
            else emem[idx] = w;
            if (push && !err_req) check(rd, 32'h0);
        end else if (rnw) check(rd, 32'h0);
    endtask

    // bounded run: a hang counts as a mismatch
    initial begin
        #2ms;
        failures++;
        end_of_test();
    end

    initial begin
        rd = $urandom(32'hDC55ED9C);
        {orun_en, orun, cmp, err, mode, mask, port, bank} = '0;
        for (int i = 0; i < 8; i++) emem[i] = 32'h11111111 * i;
        repeat (12) @(posedge clk_sys);
        rstn <= 1'b1;
        rd_ctrl();
        sel(8'h01, 4'h3);
        wr_ctrl(32'h00000F00);
        for (int i = 0; i < 8; i++) begin
            slow <= 1'($urandom_range(1, 0));
            ap(1'b0, 2'(i), $urandom);
            ap(1'b1, 2'(i), 32'h0);
        end
        wr_ctrl(32'h0000000C);
        ap(1'b0, 2'h1, $urandom);
        ap(1'b1, 2'h1, 32'h0);
        // odd entries compare equal words, even ones flip a random byte
        for (int md = 1; md < 3; md++) begin
            for (int k = 0; k < 7; k++) begin
                wr_ctrl({20'h0, lanes[k], 4'h1, 2'(md), 2'h0});
                v = emem[{port[0], 2'h2}] ^ ((k % 2) ? 32'h0 : 32'hFF << (8 * $urandom_range(3, 0)));
                ap(1'b0, 2'h2, v);
                rd_ctrl();
                ap(1'b1, 2'h2, 32'h0);
            end
        end
        wr_ctrl(32'h00000018);
        ap(1'b0, 2'h2, emem[{port[0], 2'h2}]);
        wr_ctrl(32'h00000008);
        wr_ctrl(32'h00000010);
        err_req <= 1'b1;
        ap(1'b1, 2'h0, 32'h0);
        err_req <= 1'b0;
        rd_ctrl();
        wr_ctrl(32'h00000000);
        wr_ctrl(32'h00000020);
        wr_ctrl(32'h00000001);
        xfer(1'b0, 1'b1, DPC_ADDR_CTRL, 32'h0, 2);
        orun = 1'b1;
        rd_ctrl();
        wr_ctrl(32'h00000002);
        xfer(1'b0, 1'b1, DPC_ADDR_CTRL, 32'h0, 2);
        rd_ctrl();
        sel(8'h03, 4'h5);
        n0 = n_acc;
        ap(1'b0, 2'h1, $urandom);
        ap(1'b1, 2'h1, 32'h0);
        check(n_acc, n0);
        end_of_test();
    end
endmodule
